// *** hw/gpio_mode_map.vh ***
// Mode encodings and port layout for the pin mode configuration logic
`ifndef GPIO_MODE_MAP_VH
`define GPIO_MODE_MAP_VH

// ==========================================
// Mode codes
`define MODE_ANALOG 4'h0
`define MODE_IN_FLOAT 4'h4
`define MODE_IN_PULL 4'h8
`define MODE_OUT_PP 4'h1
`define MODE_OUT_OD 4'h5
`define MODE_ALT_PP 4'h9
`define MODE_ALT_OD 4'hd

// ==========================================
// Field layout
`define MODE_FIELD_W 4
`define PINS_PER_CFG 4
`define PORT_C_PIN_SEVEN_LSB 12
`define PORT_C_PIN_SEVEN_MSB 15
`define PORT_C_PIN_SEVEN_CLEAR 16'h0fff
`define PORT_C_PIN_SEVEN_PULLED 16'h8000
`define MODE_RESET 4'h4

`endif

// *** hw/pin_mode_cell.v ***
// One pin: decodes its mode code into driver, pull and input controls
`include "gpio_mode_map.vh"

module pin_mode_cell (
  input wire clk_i,
  input wire rst_i,
  input wire [3:0] mode_i,
  input wire out_value_i,
  input wire alt_value_i,
  input wire pad_in_i,
  output reg pad_out_o,
  output reg pad_oe_o,
  output reg pull_up_o,
  output reg pull_down_o,
  output reg analog_en_o,
  output wire in_value_o
);

  // ==========================================
  // Input synchroniser
  reg sync1_q;
  reg sync2_q;
  reg [3:0] mode_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      mode_q <= `MODE_RESET;
    end else begin
      sync1_q <= pad_in_i;
      sync2_q <= sync1_q;
      mode_q <= mode_i;
    end
  end

  assign in_value_o = (mode_q == `MODE_ANALOG) ? 1'b1 : sync2_q;

  // ==========================================
  // Mode decode, registered
  reg out_d;
  reg oe_d;
  reg pu_d;
  reg pd_d;
  reg an_d;

  always @* begin
    out_d = 1'b0;
    oe_d = 1'b0;
    pu_d = 1'b0;
    pd_d = 1'b0;
    an_d = 1'b0;
    case (mode_i)
      `MODE_ANALOG: begin
        an_d = 1'b1;
      end
      `MODE_IN_FLOAT: begin
        oe_d = 1'b0;
      end
      `MODE_IN_PULL: begin
        pu_d = out_value_i;
        pd_d = ~out_value_i;
      end
      `MODE_OUT_PP: begin
        out_d = out_value_i;
        oe_d = 1'b1;
      end
      `MODE_OUT_OD: begin
        oe_d = ~out_value_i;
      end
      `MODE_ALT_PP: begin
        out_d = alt_value_i;
        oe_d = 1'b1;
      end
      `MODE_ALT_OD: begin
        oe_d = ~alt_value_i;
      end
      default: begin
        oe_d = 1'b0;
      end
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pad_out_o <= 1'b0;
      pad_oe_o <= 1'b0;
      pull_up_o <= 1'b0;
      pull_down_o <= 1'b0;
      analog_en_o <= 1'b0;
    end else begin
      pad_out_o <= out_d;
      pad_oe_o <= oe_d;
      pull_up_o <= pu_d;
      pull_down_o <= pd_d;
      analog_en_o <= an_d;
    end
  end

endmodule // pin_mode_cell

// *** hw/gpio_pin_mode_config.v ***
// Port-wide pin mode configuration: per-pin mode fields to pad controls
`include "gpio_mode_map.vh"

module gpio_pin_mode_config #(
  parameter PINS = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire [4*PINS-1:0] port_mode_config_register_i,
  input wire [PINS-1:0] pin_output_value_i,
  input wire [PINS-1:0] periph_value_i,
  input wire [PINS-1:0] pad_in_i,
  output wire [PINS-1:0] pad_out_o,
  output wire [PINS-1:0] pad_oe_o,
  output wire [PINS-1:0] pull_up_o,
  output wire [PINS-1:0] pull_down_o,
  output wire [PINS-1:0] analog_en_o,
  output reg [PINS-1:0] pin_input_value_o
);

  // ==========================================
  // Per-pin cells
  wire [PINS-1:0] in_val;

  genvar g;
  generate
    for (g = 0; g < PINS; g = g + 1) begin : pin
      // four-bit field slice; pin seven is bits 31:28 here, bits 15:12 of the high half
      pin_mode_cell u_cell (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .mode_i(port_mode_config_register_i[4*g+3:4*g]),
        .out_value_i(pin_output_value_i[g]),
        .alt_value_i(periph_value_i[g]),
        .pad_in_i(pad_in_i[g]),
        .pad_out_o(pad_out_o[g]),
        .pad_oe_o(pad_oe_o[g]),
        .pull_up_o(pull_up_o[g]),
        .pull_down_o(pull_down_o[g]),
        .analog_en_o(analog_en_o[g]),
        .in_value_o(in_val[g])
      );
    end
  endgenerate

  // ==========================================
  // Input value register; analog pins forced high inside the cell
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_input_value_o <= {PINS{1'b0}};
    end else begin
      pin_input_value_o <= in_val;
    end
  end

endmodule // gpio_pin_mode_config

// *** testbench/gpio_pin_mode_config_assertions.sv ***
// Pin zero decode checker
module gpio_pin_mode_config_assertions #(parameter PINS = 8) (
  input wire clk_i,
  input wire rst_i,
  input wire [4*PINS-1:0] port_mode_config_register_i,
  input wire [PINS-1:0] pin_output_value_i,
  input wire [PINS-1:0] pad_out_o,
  input wire [PINS-1:0] pad_oe_o,
  input wire [PINS-1:0] pull_down_o,
  input wire [PINS-1:0] pin_input_value_o
);
  timeunit 1ns;
  timeprecision 1ps;
  wire [3:0] m = port_mode_config_register_i[3:0];
  wire v = pin_output_value_i[0];
  wire e = pad_oe_o[0];
  wire o = pad_out_o[0];
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence an_s; m == 0 ##1 m == 0; endsequence
  // ====
  // Pin zero
  pp_out_a: assert property (m == 1 |=> e && o == $past(v)) else $error("drive");
  od_out_a: assert property (m == 5 |=> !o && e == !$past(v)) else $error("drive");
  od_pull_a: assert property (m == 13 |=> !o && !pull_down_o[0]) else $error("pull");
  pull_sel_a: assert property (m == 8 |=> !e && pull_down_o[0] == !$past(v)) else $error("pull");
  float_in_a: assert property (m == 4 |=> !e && !pull_down_o[0]) else $error("float");
  analog_rd_a: assert property (an_s |=> pin_input_value_o[0]) else $error("analog");
  alt_pp_a: assert property (m == 9 |=> e) else $error("drive");
  rsvd_off_a: assert property (!(m inside {0, 1, 4, 5, 8, 9, 13}) |=> !e) else $error("reserved");
endmodule // gpio_pin_mode_config_assertions
bind gpio_pin_mode_config gpio_pin_mode_config_assertions #(.PINS(PINS)) chk_inst (.*);

// *** testbench/pad_load_model.sv ***
// External pull-up on every pad
module pad_load_model (
  input wire [7:0] pad_out_i,
  input wire [7:0] pad_oe_i,
  input wire [7:0] pull_down_i,
  output wire [7:0] pad_o
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ~pull_down_i);
endmodule // pad_load_model

// *** testbench/gpio_pin_mode_config_tb.sv ***
// Bench for the pin mode decode
module gpio_pin_mode_config_tb;
  timeunit 1ns / 1ps;
  `define CK(a, b) begin checks++; if ((a) !== (b)) begin num_errors++; $display("Error %0t bad", $time); end end
  logic clk_i = 0, rst_i = 1;
  logic [31:0] port_mode_config_register_i = 32'h44444444;
  logic [7:0] pin_output_value_i = 8'h80, periph_value_i = 8'h7f;
  wire [7:0] pad_in_i, pad_out_o, pad_oe_o, pull_up_o, pull_down_o, analog_en_o, pin_input_value_o;
  int num_errors = 0, checks = 0, cyc = 0;
  gpio_pin_mode_config gpio_pin_mode_config_inst (.*);
  pad_load_model pad_load_model_inst (.pad_out_i(pad_out_o), .pad_oe_i(pad_oe_o), .pull_down_i(pull_down_o),
    .pad_o(pad_in_i));
  initial forever #2 clk_i = ~clk_i;
  always @(posedge clk_i) if (++cyc > 300) begin num_errors++; test_done; end
  task step(int n); repeat (n) @(posedge clk_i); #1; endtask
  // ====
  // Every code on pins zero and seven
  task modes;
    for (int c = 0; c < 16; c++) begin
      port_mode_config_register_i = {4'(c), 24'h444444, 4'(c)};
      step(4);
      `CK(pad_oe_o[0], c inside {1, 5, 9})
      `CK(pad_oe_o[7], c inside {1, 9, 13})
      `CK(pad_out_o[0], c == 9)
      `CK(pad_out_o[7], c == 1)
      `CK(pull_up_o[7], c == 8)
      `CK(pull_down_o[0], c == 8)
      `CK(analog_en_o[0], c == 0)
      `CK(pull_up_o[0], 1'b0)
      `CK(pin_input_value_o[0], !(c inside {1, 5, 8}))
    end
  endtask
  task test_done;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    step(3);
    rst_i = 0;
    modes;
    test_done;
  end
endmodule // gpio_pin_mode_config_tb
